// *** verilog/pdic_dev_end.sv ***
// controller end: config bank and the pin behaviour it steers
`timescale 1ns/100ps
`default_nettype none
module pdic_dev_end
	import pdic_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	pdic_link_if.dev link,
	input wire logic cfgLoad,
	input wire logic [7:0] cfgMode,
	input wire logic [7:0] cfgIface,
	input wire logic [7:0] cfgSync,
	input wire logic [15:0] cfgExt,
	input wire logic fbRdEn,
	input wire logic [15:0] fbAddr,
	output logic [7:0] fbRdData_r,
	output logic fbRdValid_r,
	input wire logic evtEof,
	input wire logic evtPulse0,
	input wire logic evtPulse1,
	input wire logic watchdogTrigger,
	input wire logic watchdogExpire,
	input wire logic [IO_W-1:0] outData,
	output logic [IO_W-1:0] inData_r,
	output logic applEvtBit2_r,
	output logic applEvtBit3_r,
	output logic tsLatch0Evt_r,
	output logic tsLatch1Evt_r,
	output logic hbRdReq_r,
	output logic hbWrReq_r,
	output logic [AD_W-1:0] hbAddr_r,
	output logic [AD_W-1:0] hbWrData_r,
	input wire logic [AD_W-1:0] hbRdData
);
	logic [7:0] modeSel_r;
	logic [7:0] ifCfg_r;
	logic [7:0] syncCfg_r;
	logic [15:0] extCfg_r;
	logic [CTL_W-1:0] ctlMeta_r;
	logic [CTL_W-1:0] ctl_r;
	logic [CTL_W-1:0] ctlPrev_r;
	logic [AD_W-1:0] adMeta_r;
	logic [AD_W-1:0] ad_r;
	logic [IO_W-1:0] ioMeta_r;
	logic [IO_W-1:0] io_r;
	logic [AD_W-1:0] adDev_r;
	logic adDevOe_r;
	logic [IO_W-1:0] ioOut_r;
	logic [IO_W-1:0] ioOe_r;
	logic [IO_W-1:0] ioOeNxt;
	logic pendRst_r;
	logic ovs_r;
	logic p0Out_r;
	logic p0Oe_r;
	logic p1Out_r;
	logic p1Oe_r;
	logic hostBus;
	logic digIo;
	logic outEvt;
	logic inEvt;
	logic [3:0] hbCur;
	logic [3:0] hbPrev;

	// host bus strobes decoded under the configured style and polarities
	function automatic logic [3:0] hb_decode(input logic [CTL_W-1:0] v,
		input logic [7:0] c);
		logic cs;
		logic en;
		logic rdDir;
		logic [3:0] d;
		cs = v[CTL_CS] == c[HB_CS_HIGH];
		en = v[CTL_WR] == c[HB_WR_POL];
		rdDir = v[CTL_RD] ^ c[HB_RD_POL];
		d = '0;
		d[HBD_ALEH] = (v[CTL_ALEH] == c[HB_ALE_HIGH]) & (cs | ~c[HB_ALE_QUAL]);
		d[HBD_ALEL] = (v[CTL_ALEL] == c[HB_ALE_HIGH]) & (cs | ~c[HB_ALE_QUAL]);
		if (c[HB_DIR_EN]) begin
			d[HBD_RD] = cs & en & rdDir;
			d[HBD_WR] = cs & en & ~rdDir;
		end else begin
			d[HBD_RD] = cs & (v[CTL_RD] == c[HB_RD_POL]);
			d[HBD_WR] = cs & en;
		end
		return d;
	endfunction

	// configuration load; loader is the only writer, no bus write path
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			modeSel_r <= CFG_RESET;
			ifCfg_r <= CFG_RESET;
			syncCfg_r <= CFG_RESET;
			extCfg_r <= EXT_RESET;
		end else if (cfgLoad) begin
			modeSel_r <= cfgMode;
			ifCfg_r <= cfgIface;
			syncCfg_r <= cfgSync;
			// reserved high byte and bidirectional mode read as zero
			extCfg_r <= {EXT_RSV_ZERO, (cfgMode == MODE_DIGIO &&
				cfgIface[IF_BIDIR]) ? DIR_ZERO : cfgExt[DIR_W-1:0]};
		end
	end

	// two-stage synchronisers on every pin input
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ctlMeta_r <= '0;
			ctl_r <= '0;
			ctlPrev_r <= '0;
			adMeta_r <= '0;
			ad_r <= '0;
			ioMeta_r <= '0;
			io_r <= '0;
		end else begin
			ctlMeta_r <= {link.pulse1Level, link.pulse0Level,
				link.inputLatchStrobe, link.addrLatchLo, link.addrLatchHi,
				link.hbWrEn, link.hbRdDir, link.hbCs};
			ctl_r <= ctlMeta_r;
			ctlPrev_r <= ctl_r;
			adMeta_r <= link.adLevel;
			ad_r <= adMeta_r;
			ioMeta_r <= link.ioLevel;
			io_r <= ioMeta_r;
		end
	end

	// mode decode and event selection
	always_comb begin
		hostBus = pdic_is_host_bus(modeSel_r);
		digIo = modeSel_r == MODE_DIGIO;
		hbCur = hostBus ? hb_decode(ctl_r, ifCfg_r) : '0;
		hbPrev = hostBus ? hb_decode(ctlPrev_r, ifCfg_r) : '0;
		outEvt = 1'b0;
		if (ifCfg_r[IF_OVS_WD]) begin
			outEvt = watchdogTrigger;
		end else begin
			unique case (ifCfg_r[IF_OUTSEL_LO +: 2])
				SEL_EOF: outEvt = evtEof;
				SEL_LATCH: outEvt = 1'b0; // reserved code: never updates
				SEL_P0: outEvt = evtPulse0;
				SEL_P1: outEvt = evtPulse1;
			endcase
		end
		outEvt = outEvt & digIo;
		unique case (ifCfg_r[IF_INSEL_LO +: 2])
			SEL_EOF: inEvt = evtEof;
			SEL_LATCH: inEvt = ctl_r[CTL_LATIN] & ~ctlPrev_r[CTL_LATIN];
			SEL_P0: inEvt = evtPulse0;
			SEL_P1: inEvt = evtPulse1;
		endcase
		inEvt = inEvt & digIo;
	end

	// output data with immediate or deferred watchdog reset
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ioOut_r <= '0;
			pendRst_r <= 1'b0;
		end else if (digIo && watchdogExpire && !ifCfg_r[IF_WD_DEFER]) begin
			ioOut_r <= '0;
			pendRst_r <= 1'b0;
		end else begin
			if (outEvt) begin
				ioOut_r <= pendRst_r ? '0 : outData;
			end
			// a new expiry in the event cycle stays pending: set wins
			pendRst_r <= (digIo & watchdogExpire) | (pendRst_r & ~outEvt);
		end
	end

	// pair directions; bidirectional mode drives every pin
	for (genvar k = 0; k < DIR_W; k++) begin : g_pair
		assign ioOeNxt[2*k +: 2] = {2{digIo & (ifCfg_r[IF_BIDIR] |
			extCfg_r[k])}};
	end

	// pin-side outputs, all registered
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ioOe_r <= '0;
			ovs_r <= 1'b0;
			inData_r <= '0;
		end else begin
			ioOe_r <= ioOeNxt;
			ovs_r <= pdic_lvl(outEvt, ~ifCfg_r[IF_OVS_LOW]);
			if (inEvt) begin
				inData_r <= io_r;
			end
		end
	end

	// pulse pins, latch inputs and event mapping
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			{p0Out_r, p0Oe_r} <= DRV_OFF;
			{p1Out_r, p1Oe_r} <= DRV_OFF;
			tsLatch0Evt_r <= 1'b0;
			tsLatch1Evt_r <= 1'b0;
			applEvtBit2_r <= 1'b0;
			applEvtBit3_r <= 1'b0;
		end else begin
			{p0Out_r, p0Oe_r} <= syncCfg_r[SY_P0_OUT] ? pdic_drive(
				syncCfg_r[SY_P0_DRV_LO +: 2], evtPulse0) : DRV_OFF;
			{p1Out_r, p1Oe_r} <= syncCfg_r[SY_P1_OUT] ? pdic_drive(
				syncCfg_r[SY_P1_DRV_LO +: 2], evtPulse1) : DRV_OFF;
			tsLatch0Evt_r <= ~syncCfg_r[SY_P0_OUT] & ctl_r[CTL_TS0] &
				~ctlPrev_r[CTL_TS0];
			tsLatch1Evt_r <= ~syncCfg_r[SY_P1_OUT] & ctl_r[CTL_TS1] &
				~ctlPrev_r[CTL_TS1];
			applEvtBit2_r <= evtPulse0 & syncCfg_r[SY_P0_MAP];
			applEvtBit3_r <= evtPulse1 & syncCfg_r[SY_P1_MAP];
		end
	end

	// host bus access: address at latch trailing edge, data on strobes
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			hbAddr_r <= '0;
			hbWrData_r <= '0;
			hbRdReq_r <= 1'b0;
			hbWrReq_r <= 1'b0;
			adDev_r <= '0;
			adDevOe_r <= 1'b0;
		end else begin
			if (hbPrev[HBD_ALEH] && !hbCur[HBD_ALEH]) begin
				hbAddr_r[AD_W-1:BYTE_W] <= ad_r[AD_W-1:BYTE_W];
			end
			if (hbPrev[HBD_ALEL] && !hbCur[HBD_ALEL]) begin
				hbAddr_r[BYTE_W-1:0] <= ad_r[BYTE_W-1:0];
			end
			hbRdReq_r <= hbCur[HBD_RD] & ~hbPrev[HBD_RD];
			// write data taken as the strobe ends, when it is surely stable
			hbWrReq_r <= hbPrev[HBD_WR] & ~hbCur[HBD_WR];
			if (hbPrev[HBD_WR] && !hbCur[HBD_WR]) begin
				hbWrData_r <= ad_r;
			end
			if (hbRdReq_r) begin
				adDev_r <= hbRdData;
			end
			adDevOe_r <= hbCur[HBD_RD];
		end
	end

	// fieldbus read port, one cycle latency, unmapped reads zero
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			fbRdValid_r <= 1'b0;
			fbRdData_r <= CFG_RESET;
		end else begin
			fbRdValid_r <= fbRdEn;
			if (fbRdEn) begin
				case (fbAddr)
					IFACE_CFG_ADDR: fbRdData_r <= ifCfg_r;
					SYNC_CFG_ADDR: fbRdData_r <= syncCfg_r;
					EXT_CFG_LO_ADDR: fbRdData_r <= extCfg_r[BYTE_W-1:0];
					EXT_CFG_HI_ADDR: fbRdData_r <= extCfg_r[15:BYTE_W];
					default: fbRdData_r <= CFG_RESET;
				endcase
			end
		end
	end

	assign link.adDev = adDev_r;
	assign link.adDevOe = adDevOe_r;
	assign link.ioDev = ioOut_r;
	assign link.ioDevOe = ioOe_r;
	assign link.outputValidStrobe = ovs_r;
	assign link.pulse0Out = p0Out_r;
	assign link.pulse0Oe = p0Oe_r;
	assign link.pulse1Out = p1Out_r;
	assign link.pulse1Oe = p1Oe_r;
endmodule
`default_nettype wire

// *** verilog/pdic_pkg.sv ***
// shared constants, types and decoders of the interface config bank
package pdic_pkg;
	// byte addresses seen from the fieldbus side
	localparam logic [15:0] IFACE_CFG_ADDR = 16'h0150;
	localparam logic [15:0] SYNC_CFG_ADDR = 16'h0151;
	localparam logic [15:0] EXT_CFG_LO_ADDR = 16'h0152;
	localparam logic [15:0] EXT_CFG_HI_ADDR = 16'h0153;
	// interface mode selector codes
	localparam logic [7:0] MODE_DIGIO = 8'h04;
	localparam logic [7:0] MODE_SPI = 8'h80;
	localparam logic [7:0] MODE_HB_FIRST = 8'h88;
	localparam logic [7:0] MODE_HB_LAST = 8'h8d;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [15:0] EXT_RESET = 16'h0000;
	localparam logic [7:0] EXT_RSV_ZERO = 8'h00;
	localparam logic [7:0] DIR_ZERO = 8'h00;
	localparam int BYTE_W = 8;
	localparam int DIR_W = 8;
	localparam int IO_W = 16;
	localparam int AD_W = 16;
	// digital I/O layout of the interface config byte
	localparam int IF_OUTSEL_LO = 6;
	localparam int IF_INSEL_LO = 4;
	localparam int IF_WD_DEFER = 3;
	localparam int IF_BIDIR = 2;
	localparam int IF_OVS_WD = 1;
	localparam int IF_OVS_LOW = 0;
	// host bus layout of the same byte
	localparam int HB_ALE_QUAL = 7;
	localparam int HB_DIR_EN = 6;
	localparam int HB_CS_HIGH = 5;
	localparam int HB_RD_POL = 4;
	localparam int HB_WR_POL = 3;
	localparam int HB_ALE_HIGH = 2;
	// sync/latch pin config byte
	localparam int SY_P1_MAP = 7;
	localparam int SY_P1_OUT = 6;
	localparam int SY_P1_DRV_LO = 4;
	localparam int SY_P0_MAP = 3;
	localparam int SY_P0_OUT = 2;
	localparam int SY_P0_DRV_LO = 0;
	// sample selection codes
	localparam logic [1:0] SEL_EOF = 2'h0;
	localparam logic [1:0] SEL_LATCH = 2'h1;
	localparam logic [1:0] SEL_P0 = 2'h2;
	localparam logic [1:0] SEL_P1 = 2'h3;
	// pulse driver codes
	localparam logic [1:0] DRV_PP_LOW = 2'h0;
	localparam logic [1:0] DRV_OD_LOW = 2'h1;
	localparam logic [1:0] DRV_PP_HIGH = 2'h2;
	localparam logic [1:0] DRV_OFF = 2'h0;
	// synchronised control pin vector positions
	localparam int CTL_W = 8;
	localparam int CTL_CS = 0;
	localparam int CTL_RD = 1;
	localparam int CTL_WR = 2;
	localparam int CTL_ALEH = 3;
	localparam int CTL_ALEL = 4;
	localparam int CTL_LATIN = 5;
	localparam int CTL_TS0 = 6;
	localparam int CTL_TS1 = 7;
	// decoded host bus strobes
	localparam int HBD_RD = 0;
	localparam int HBD_WR = 1;
	localparam int HBD_ALEH = 2;
	localparam int HBD_ALEL = 3;
	// host bus phase hold, least time so rounded up
	localparam int CLK_PERIOD_NS = 40;
	localparam int HB_HOLD_NS = 400;
	localparam int HB_HOLD_CYC = (HB_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HOLD_LAST = 4'(HB_HOLD_CYC - 1);
	localparam logic [3:0] HOLD_ZERO = 4'h0;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_ALE = 3'h1,
		H_GAP = 3'h3,
		H_STRB = 3'h2,
		H_END = 3'h6
	} pdic_hstate_type;

	// pin level for an active flag under a polarity
	function automatic logic pdic_lvl(input logic act, input logic actHigh);
		return actHigh ? act : ~act;
	endfunction

	function automatic logic pdic_is_host_bus(input logic [7:0] mode);
		return (mode >= MODE_HB_FIRST) && (mode <= MODE_HB_LAST);
	endfunction

	// {out, oe} of a pulse pin for a driver code
	function automatic logic [1:0] pdic_drive(input logic [1:0] code,
		input logic pulse);
		unique case (code)
			DRV_PP_LOW: return {~pulse, 1'b1};
			DRV_OD_LOW: return {1'b0, pulse};
			DRV_PP_HIGH: return {pulse, 1'b1};
			default: return {1'b1, pulse};
		endcase
	endfunction
endpackage

// *** verilog/pdic_link_if.sv ***
// pins between the controller end and the host or I/O end
`timescale 1ns/100ps
`default_nettype none
interface pdic_link_if;
	import pdic_pkg::*;
	logic hbCs;
	logic hbRdDir;
	logic hbWrEn;
	logic addrLatchHi;
	logic addrLatchLo;
	logic [AD_W-1:0] adHost;
	logic adHostOe;
	logic [AD_W-1:0] adDev;
	logic adDevOe;
	logic [AD_W-1:0] adLevel;
	logic [IO_W-1:0] ioDev;
	logic [IO_W-1:0] ioDevOe;
	logic [IO_W-1:0] ioFar;
	logic [IO_W-1:0] ioLevel;
	logic inputLatchStrobe;
	logic outputValidStrobe;
	logic pulse0Out;
	logic pulse0Oe;
	logic pulse1Out;
	logic pulse1Oe;
	logic tsLatch0Far;
	logic tsLatch1Far;
	logic pulse0Level;
	logic pulse1Level;

	// wire resolution; a pin the device end leaves undriven reads as the far end's value, the address/data bus as zero when neither end drives
	assign adLevel = adDevOe ? adDev : (adHostOe ? adHost : '0);
	assign ioLevel = (ioDev & ioDevOe) | (ioFar & ~ioDevOe);
	assign pulse0Level = pulse0Oe ? pulse0Out : tsLatch0Far;
	assign pulse1Level = pulse1Oe ? pulse1Out : tsLatch1Far;

	modport dev (
		input hbCs, hbRdDir, hbWrEn, addrLatchHi, addrLatchLo, adLevel,
		ioLevel, inputLatchStrobe, pulse0Level, pulse1Level,
		output adDev, adDevOe, ioDev, ioDevOe, outputValidStrobe,
		pulse0Out, pulse0Oe, pulse1Out, pulse1Oe
	);
	modport host (
		input adLevel,
		output hbCs, hbRdDir, hbWrEn, addrLatchHi, addrLatchLo, adHost,
		adHostOe, ioFar, inputLatchStrobe, tsLatch0Far, tsLatch1Far
	);
endinterface
`default_nettype wire

// *** verilog/pdic_host_end.sv ***
// host end: drives multiplexed bus cycles and the far I/O levels
`timescale 1ns/100ps
`default_nettype none
module pdic_host_end
	import pdic_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	pdic_link_if.host link,
	input wire logic [7:0] cfgIface,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [AD_W-1:0] reqAddr,
	input wire logic [AD_W-1:0] reqWrData,
	output logic reqReady_r,
	output logic rspValid_r,
	output logic [AD_W-1:0] rspData_r,
	input wire logic [IO_W-1:0] ioDrive,
	input wire logic latchDrive,
	input wire logic tsLatch0Drive,
	input wire logic tsLatch1Drive
);
	pdic_hstate_type state_r;
	logic [3:0] holdCnt_r;
	logic isWrite_r;
	logic [AD_W-1:0] addr_r;
	logic [AD_W-1:0] data_r;
	logic [AD_W-1:0] adMeta_r;
	logic [AD_W-1:0] ad_r;
	logic holdDone;
	logic cs_r;
	logic rd_r;
	logic wr_r;
	logic aleH_r;
	logic aleL_r;
	logic [AD_W-1:0] adOut_r;
	logic adOe_r;
	logic [IO_W-1:0] ioFar_r;
	logic latch_r;
	logic ts0_r;
	logic ts1_r;

	assign holdDone = holdCnt_r == HOLD_LAST;

	// each phase is held long enough for the far synchronisers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_r <= H_IDLE;
			holdCnt_r <= HOLD_ZERO;
			isWrite_r <= 1'b0;
			addr_r <= '0;
			data_r <= '0;
			rspValid_r <= 1'b0;
			rspData_r <= '0;
		end else begin
			rspValid_r <= 1'b0;
			holdCnt_r <= (state_r == H_IDLE || holdDone) ? HOLD_ZERO :
				holdCnt_r + 4'h1;
			unique case (state_r)
				H_IDLE: if (reqValid) begin
					isWrite_r <= reqWrite;
					addr_r <= reqAddr;
					data_r <= reqWrData;
					state_r <= H_ALE;
				end
				H_ALE: if (holdDone) state_r <= H_GAP;
				H_GAP: if (holdDone) state_r <= H_STRB;
				H_STRB: if (holdDone) begin
					if (!isWrite_r) rspData_r <= ad_r;
					state_r <= H_END;
				end
				H_END: if (holdDone) begin
					rspValid_r <= 1'b1;
					state_r <= H_IDLE;
				end
				default: state_r <= H_IDLE;
			endcase
		end
	end

	// read data arrives from a pin, so it is synchronised first
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			adMeta_r <= '0;
			ad_r <= '0;
		end else begin
			adMeta_r <= link.adLevel;
			ad_r <= adMeta_r;
		end
	end

	// pin levels follow the state one cycle later, polarity applied
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			reqReady_r <= 1'b0;
			cs_r <= pdic_lvl(1'b0, CFG_RESET[HB_CS_HIGH]);
			rd_r <= pdic_lvl(1'b0, CFG_RESET[HB_RD_POL]);
			wr_r <= pdic_lvl(1'b0, CFG_RESET[HB_WR_POL]);
			aleH_r <= pdic_lvl(1'b0, CFG_RESET[HB_ALE_HIGH]);
			aleL_r <= pdic_lvl(1'b0, CFG_RESET[HB_ALE_HIGH]);
			adOut_r <= '0;
			adOe_r <= 1'b0;
		end else begin
			reqReady_r <= state_r == H_IDLE && !reqValid;
			cs_r <= pdic_lvl(state_r != H_IDLE, cfgIface[HB_CS_HIGH]);
			aleH_r <= pdic_lvl(state_r == H_ALE, cfgIface[HB_ALE_HIGH]);
			aleL_r <= pdic_lvl(state_r == H_ALE, cfgIface[HB_ALE_HIGH]);
			if (cfgIface[HB_DIR_EN]) begin
				rd_r <= ~isWrite_r ^ cfgIface[HB_RD_POL];
				wr_r <= pdic_lvl(state_r == H_STRB, cfgIface[HB_WR_POL]);
			end else begin
				rd_r <= pdic_lvl(state_r == H_STRB && !isWrite_r,
					cfgIface[HB_RD_POL]);
				wr_r <= pdic_lvl(state_r == H_STRB && isWrite_r,
					cfgIface[HB_WR_POL]);
			end
			// address stays on the bus one phase past the latch (ale qual)
			adOut_r <= (state_r == H_ALE || state_r == H_GAP) ? addr_r : data_r;
			adOe_r <= state_r == H_ALE || state_r == H_GAP ||
				(isWrite_r && (state_r == H_STRB || state_r == H_END));
		end
	end

	// far-end I/O and latch levels
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ioFar_r <= '0;
			latch_r <= 1'b0;
			ts0_r <= 1'b0;
			ts1_r <= 1'b0;
		end else begin
			ioFar_r <= ioDrive;
			latch_r <= latchDrive;
			ts0_r <= tsLatch0Drive;
			ts1_r <= tsLatch1Drive;
		end
	end

	assign link.hbCs = cs_r;
	assign link.hbRdDir = rd_r;
	assign link.hbWrEn = wr_r;
	assign link.addrLatchHi = aleH_r;
	assign link.addrLatchLo = aleL_r;
	assign link.adHost = adOut_r;
	assign link.adHostOe = adOe_r;
	assign link.ioFar = ioFar_r;
	assign link.inputLatchStrobe = latch_r;
	assign link.tsLatch0Far = ts0_r;
	assign link.tsLatch1Far = ts1_r;
endmodule
`default_nettype wire

// *** verification/pdic_properties.sv ***
// link-pin properties of the interface config bank
`timescale 1ns/100ps
`default_nettype none
module pdic_properties
	import pdic_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hbCs,
	input wire logic hbRdDir,
	input wire logic hbWrEn,
	input wire logic addrLatchHi,
	input wire logic addrLatchLo,
	input wire logic adHostOe,
	input wire logic adDevOe,
	input wire logic [IO_W-1:0] ioDevOe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// a moved bus pin keeps its level for the next eight cycles
	sequence s_held(s);
		$stable(s) [*8];
	endsequence
	// read drive must end within 16 cycles of starting
	sequence s_released;
		##[1:16] !adDevOe;
	endsequence
	property p_ad_excl;
		!(adHostOe && adDevOe);
	endproperty
	property p_ale_pair;
		addrLatchHi == addrLatchLo;
	endproperty
	property p_ale_hold;
		$changed(addrLatchHi) |=> s_held(addrLatchHi);
	endproperty
	property p_cs_hold;
		$changed(hbCs) |=> s_held(hbCs);
	endproperty
	property p_rd_hold;
		$changed(hbRdDir) |=> s_held(hbRdDir);
	endproperty
	property p_wr_hold;
		$changed(hbWrEn) |=> s_held(hbWrEn);
	endproperty
	// both pins of a pair always share one direction
	property p_pair_oe;
		((ioDevOe ^ (ioDevOe >> 1)) & 16'h5555) == 16'h0000;
	endproperty
	property p_dev_release;
		$rose(adDevOe) |-> s_released;
	endproperty
	a_ad_excl: assert property (p_ad_excl)
		else $error("both ends drive the address/data bus");
	a_ale_pair: assert property (p_ale_pair)
		else $error("address latch strobes differ");
	a_ale_hold: assert property (p_ale_hold)
		else $error("address latch strobe phase too short");
	a_cs_hold: assert property (p_cs_hold)
		else $error("chip select phase too short");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read or direction pin phase too short");
	a_wr_hold: assert property (p_wr_hold)
		else $error("write or enable pin phase too short");
	a_pair_oe: assert property (p_pair_oe)
		else $error("pin pair enables differ");
	a_dev_release: assert property (p_dev_release)
		else $error("device holds the bus too long");
endmodule
`default_nettype wire

// *** verification/process_data_iface_config_test.sv ***
// self-checking bench: both ends of the config bank joined by the link
`timescale 1ns/100ps
`default_nettype none
module process_data_iface_config_test;
	import pdic_pkg::*;
	logic mclk, rstn, cfgLoad, fbRdEn, fbRdValid_r, reqValid, reqWrite;
	logic reqReady_r, rspValid_r, latchDrive, ts0Drive, ts1Drive;
	logic applEvtBit2_r, applEvtBit3_r, tsLatch0Evt_r, tsLatch1Evt_r;
	logic hbRdReq_r, hbWrReq_r;
	logic [4:0] evts;
	logic [7:0] cfgMode, cfgIface, cfgSync, hCfg, fbRdData_r;
	logic [15:0] cfgExt, fbAddr, outData, inData_r, hbAddr_r, hbWrData_r;
	logic [15:0] hbRdData, reqAddr, reqWrData, rspData_r, ioDrive, ioExp;
	logic [15:0] wrAddr, wrData, rdAddr;
	logic [7:0] hbCfgs [6] = '{8'h00, 8'h7c, 8'h40, 8'hbc, 8'he0, 8'h9c};
	int checks, miscompares, cyc;
	pdic_link_if u_link ();
	pdic_dev_end u_pdic_dev_end (.mclk(mclk), .rstn(rstn), .link(u_link),
		.cfgLoad(cfgLoad), .cfgMode(cfgMode), .cfgIface(cfgIface),
		.cfgSync(cfgSync), .cfgExt(cfgExt), .fbRdEn(fbRdEn), .fbAddr(fbAddr),
		.fbRdData_r(fbRdData_r), .fbRdValid_r(fbRdValid_r), .evtEof(evts[0]),
		.evtPulse0(evts[1]), .evtPulse1(evts[2]), .watchdogTrigger(evts[3]),
		.watchdogExpire(evts[4]), .outData(outData), .inData_r(inData_r),
		.applEvtBit2_r(applEvtBit2_r), .applEvtBit3_r(applEvtBit3_r),
		.tsLatch0Evt_r(tsLatch0Evt_r), .tsLatch1Evt_r(tsLatch1Evt_r),
		.hbRdReq_r(hbRdReq_r), .hbWrReq_r(hbWrReq_r), .hbAddr_r(hbAddr_r),
		.hbWrData_r(hbWrData_r), .hbRdData(hbRdData));
	pdic_host_end u_pdic_host_end (.mclk(mclk), .rstn(rstn), .link(u_link),
		.cfgIface(hCfg), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqWrData(reqWrData), .reqReady_r(reqReady_r),
		.rspValid_r(rspValid_r), .rspData_r(rspData_r), .ioDrive(ioDrive),
		.latchDrive(latchDrive), .tsLatch0Drive(ts0Drive),
		.tsLatch1Drive(ts1Drive));
	pdic_properties u_pdic_properties (.mclk(mclk), .rstn(rstn),
		.hbCs(u_link.hbCs), .hbRdDir(u_link.hbRdDir), .hbWrEn(u_link.hbWrEn),
		.addrLatchHi(u_link.addrLatchHi), .addrLatchLo(u_link.addrLatchLo),
		.adHostOe(u_link.adHostOe), .adDevOe(u_link.adDevOe),
		.ioDevOe(u_link.ioDevOe));
	// clock and hang guard; the run needs well under 10000 cycles
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// latch what the device end hands over from each bus cycle
	always @(posedge mclk) begin
		if (hbWrReq_r === 1'b1) begin
			wrAddr = hbAddr_r;
			wrData = hbWrData_r;
		end
		if (hbRdReq_r === 1'b1)
			rdAddr = hbAddr_r;
	end
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic int hi(input logic b);
		return int'(b === 1'b1);
	endfunction
	function automatic logic upd(input logic [7:0] f, input int ev);
		return f[IF_OVS_WD] ? ev == 3 : (ev < 3 && f[7:6] == 2'(ev ? ev + 1 : 0));
	endfunction
	function automatic logic [15:0] oe_exp(input logic [7:0] f,
		input logic [15:0] e);
		logic [15:0] r;
		for (int k = 0; k < DIR_W; k++)
			r[2*k +: 2] = {2{e[k]}};
		return f[IF_BIDIR] ? 16'hffff : r;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic load(input logic [7:0] m, input logic [7:0] f,
		input logic [7:0] s, input logic [15:0] e);
		@(posedge mclk);
		cfgLoad <= 1'b1;
		cfgMode <= m;
		cfgIface <= f;
		cfgSync <= s;
		cfgExt <= e;
		hCfg <= f;
		@(posedge mclk);
		cfgLoad <= 1'b0;
		tick(12);
	endtask
	// five byte reads, the last one just past the bank
	task automatic regs(input logic [39:0] e);
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			fbRdEn <= 1'b1;
			fbAddr <= IFACE_CFG_ADDR + 16'(i);
			@(posedge mclk);
			fbRdEn <= 1'b0;
			#1 check("cfg byte", {8'h00, e[8*i +: 8]}, {8'h00, fbRdData_r});
			check("read valid", 16'h0001, 16'(fbRdValid_r));
		end
	endtask
	// one event pulse, then watch the strobe for four cycles and check the outputs once
	task automatic fire(input int ev, input logic [15:0] d, input logic hit,
		input logic [15:0] exp);
		int hits;
		@(posedge mclk);
		outData <= d;
		evts <= 5'(1 << ev);
		@(posedge mclk);
		evts <= 5'h00;
		hits = 0;
		repeat (4) begin
			#1 hits += hi(u_link.outputValidStrobe === ~cfgIface[IF_OVS_LOW]);
			@(posedge mclk);
		end
		check("strobe", 16'(hit), 16'(hits));
		check("outputs", exp, u_link.ioDev);
	endtask
	task automatic hb(input logic w, input logic [15:0] a,
		input logic [15:0] d);
		int n;
		@(posedge mclk);
		#1 check("bus ready", 16'h0001, 16'(reqReady_r));
		@(posedge mclk);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqWrData <= d;
		@(posedge mclk);
		reqValid <= 1'b0;
		n = 0;
		while (n < 60 && rspValid_r !== 1'b1) begin
			@(posedge mclk);
			#1 n++;
		end
		check("bus answer", 16'h0001, 16'(n < 60));
		tick(12);
	endtask
	initial begin
		logic [7:0] f, s;
		logic [15:0] e, d;
		int h0, h1, a2, a3;
		{rstn, cfgLoad, fbRdEn, reqValid, reqWrite, latchDrive} = '0;
		{ts0Drive, ts1Drive, evts, cfgMode, cfgIface, cfgSync, hCfg} = '0;
		{cfgExt, fbAddr, outData, hbRdData, reqAddr, reqWrData} = '0;
		ioDrive = '0;
		ioExp = '0;
		void'($urandom(32'h53e5e7a5));
		tick(3);
		rstn <= 1'b1;
		regs(40'h0);
		for (int i = 0; i < 6; i++) begin
			f = $urandom;
			s = $urandom;
			e = $urandom;
			f[IF_BIDIR] = f[IF_BIDIR] | (i == 0);
			load(MODE_DIGIO, f, s, e);
			regs({16'h0, f[IF_BIDIR] ? 8'h00 : e[7:0], s, f});
			check("pin enables", oe_exp(f, e), u_link.ioDevOe);
		end
		load(MODE_SPI, 8'h04, 8'h00, 16'h00ff);
		regs({24'h00ff00, 8'h04});
		check("pin enables", 16'h0000, u_link.ioDevOe);
		$display("test config images done");
		for (int i = 0; i < 8; i++) begin
			f = {i[1:0], 3'h0, 1'($urandom), i[2], 1'($urandom)};
			load(MODE_DIGIO, f, 8'h00, 16'h00ff);
			for (int ev = 0; ev < 4; ev++) begin
				d = $urandom;
				if (upd(f, ev))
					ioExp = d;
				fire(ev, d, upd(f, ev), ioExp);
			end
		end
		load(MODE_DIGIO, 8'h00, 8'h00, 16'h00ff);
		fire(0, 16'h5a5a, 1'b1, 16'h5a5a);
		fire(4, 16'h1234, 1'b0, 16'h0000);
		load(MODE_DIGIO, 8'h08, 8'h00, 16'h00ff);
		fire(0, 16'h5a5a, 1'b1, 16'h5a5a);
		fire(4, 16'h1234, 1'b0, 16'h5a5a);
		fire(0, 16'h1234, 1'b1, 16'h0000);
		fire(0, 16'h1234, 1'b1, 16'h1234);
		ioExp = 16'h1234;
		$display("test output events done");
		for (int i = 0; i < 4; i++) begin
			load(MODE_DIGIO, {2'h1, i[1:0], 4'h0}, 8'h00, 16'h0000);
			d = $urandom;
			ioDrive <= d;
			tick(6);
			check("early sample", 16'h0001, 16'(inData_r !== d));
			latchDrive <= (i == 1);
			if (i != 1)
				fire(i ? i - 1 : 0, outData, 1'b0, ioExp);
			tick(6);
			latchDrive <= 1'b0;
			check("inputs", d, inData_r);
		end
		$display("test input sampling done");
		for (int c = 0; c < 4; c++) begin
			s = {c[0], 1'b1, c[1:0], c[0], 1'b1, c[1:0]};
			load(MODE_DIGIO, 8'h40, s, 16'h0000);
			check("pin idle", 16'(c[0] ? {c[1], 1'b0} : {~c[1], 1'b1}),
				{14'h0, u_link.pulse0Out, u_link.pulse0Oe});
			@(posedge mclk);
			evts <= 5'h06;
			@(posedge mclk);
			evts <= 5'h00;
			{h0, h1, a2, a3} = '0;
			repeat (4) begin
				#1 h0 += hi({u_link.pulse0Out, u_link.pulse0Oe} === {c[1], 1'b1});
				h1 += hi({u_link.pulse1Out, u_link.pulse1Oe} === {c[1], 1'b1});
				a2 += hi(applEvtBit2_r);
				a3 += hi(applEvtBit3_r);
				@(posedge mclk);
			end
			check("pulse 0 pin", 16'h0001, 16'(h0));
			check("pulse 1 pin", 16'h0001, 16'(h1));
			check("event bit 2", 16'(c[0]), 16'(a2));
			check("event bit 3", 16'(c[0]), 16'(a3));
		end
		load(MODE_DIGIO, 8'h40, 8'h00, 16'h0000);
		ts0Drive <= 1'b1;
		ts1Drive <= 1'b1;
		{a2, a3} = '0;
		repeat (8) begin
			@(posedge mclk);
			#1 a2 += hi(tsLatch0Evt_r);
			a3 += hi(tsLatch1Evt_r);
		end
		check("latch 0 event", 16'h0001, 16'(a2));
		check("latch 1 event", 16'h0001, 16'(a3));
		$display("test pulse pins done");
		for (int i = 0; i < 8; i++) begin
			f = (i < 6) ? hbCfgs[i] : 8'($urandom) & 8'hfc;
			load(MODE_HB_FIRST + 8'(i % 6), f, 8'h00, 16'h0000);
			e = $urandom;
			d = $urandom;
			hbRdData <= ~d;
			hb(1'b1, e, d);
			check("write address", e, wrAddr);
			check("write data", d, wrData);
			hb(1'b0, ~e, 16'h0000);
			check("read address", ~e, rdAddr);
			check("read data", ~d, rspData_r);
		end
		$display("test host bus done");
		report_and_stop();
	end
endmodule
`default_nettype wire
